// File: rtl/uefu_host.sv
// Firmware-side sequencer that drives the USB endpoint unit register port.
// Assumes an AHB-Lite master issuing single word transfers, and a device
// register port that accepts one access per clock with read data in the same cycle as the read strobe.
module uefu_host
   import uefu_pkg::*;
#(
   parameter int SIZE_EP0 = 32,
   parameter int SIZE_SMALL = 8,
   parameter int SIZE_LARGE = 64
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [3:0] dev_addr,
   output logic dev_wr,
   output logic dev_rd,
   output logic [7:0] dev_wdata,
   input wire logic [7:0] dev_rdata,
   input wire logic clock_ready
);
   import uefu_pkg::*;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic ph_wr;
      logic [7:0] ph_addr;
      logic [3:0] dev_addr;
      logic dev_wr;
      logic dev_rd;
      logic [7:0] dev_wdata;
      logic [3:0] cmd;
      logic [15:0] arg;
      logic busy;
      logic error;
      logic [7:0] result;
      logic [7:0] ctl_shadow;
      logic [6:0] wr_count;
      logic [6:0] rd_count;
      logic clk_s1;
      logic clk_s2;
      logic pend_cap;
      uefu_state_e state;
   } uefu_state_s;

   uefu_state_s cur, nxt;

   // ==========================================================
   // Helpers
   function automatic logic [6:0] fifo_size(input logic [2:0] ep);
      if (ep == 3'h0)
      begin
         fifo_size = 7'(SIZE_EP0);
      end
      else if (ep <= 3'h3)
      begin
         fifo_size = 7'(SIZE_SMALL);
      end
      else
      begin
         fifo_size = 7'(SIZE_LARGE);
      end
   endfunction

   function automatic logic [7:0] ep_control(input logic en, input logic dir,
                                              input logic [1:0] ty, input logic [2:0] ep);
      logic [7:0] v;
      logic [1:0] t;
      v = BYTE_ZERO;
      // The direction is judged on the type actually written, so a forced control drops it.
      t = (ep == 3'h0) ? TYPE_CONTROL
                       : (ep == PINGPONG_EP && ty == TYPE_CONTROL) ? TYPE_BULK : ty;
      v[CON_ENABLE] = en;
      v[CON_DIRECTION] = (t == TYPE_CONTROL) ? 1'b0 : dir;
      v[1:0] = t;
      ep_control = v;
   endfunction

   logic [2:0] ep;
   logic [7:0] status_word;
   assign ep = cur.arg[10:8];
   assign status_word = {cur.busy, cur.error, cur.clk_s2, 5'(cur.state)};

   // ==========================================================
   // Next state
   always_comb
   begin
      nxt = cur;
      nxt.clk_s1 = clock_ready;
      nxt.clk_s2 = cur.clk_s1;
      nxt.dev_wr = 1'b0;
      nxt.dev_rd = 1'b0;
      nxt.hreadyout = 1'b1;
      // AHB address phase capture.
      if (hsel && hready && htrans[1])
      begin
         nxt.ph_wr = hwrite;
         nxt.ph_addr = haddr[7:0];
         nxt.pend_cap = 1'b1;
         unique case (haddr[7:0])
            REG_STATUS: nxt.hrdata = {24'h00_0000, status_word};
            REG_RESULT: nxt.hrdata = {24'h00_0000, cur.result};
            REG_ARG: nxt.hrdata = {16'h0000, cur.arg};
            default: nxt.hrdata = 32'h0000_0000;
         endcase
      end
      else
      begin
         nxt.pend_cap = 1'b0;
      end
      // AHB data phase write.
      if (cur.pend_cap && cur.ph_wr)
      begin
         if (cur.ph_addr == REG_ARG)
         begin
            nxt.arg = hwdata[15:0];
         end
         else if (cur.ph_addr == REG_COMMAND && !cur.busy)
         begin
            nxt.cmd = hwdata[3:0];
            nxt.busy = 1'b1;
            nxt.error = 1'b0;
            nxt.state = ST_INDEX;
         end
      end
      unique case (cur.state)
         ST_IDLE:
         begin
            // A command write above moves the machine on; nothing else to do here.
         end
         ST_INDEX:
         begin
            // Endpoint commands select the endpoint first.
            if (cur.cmd >= CMD_CONFIG_EP)
            begin
               nxt.dev_wr = 1'b1;
               nxt.dev_addr = DEV_EP_INDEX;
               nxt.dev_wdata = {5'h00, ep};
            end
            nxt.state = ST_ACCESS;
         end
         ST_ACCESS:
         begin
            nxt.state = ST_DONE;
            unique case (uefu_cmd_e'(cur.cmd))
               CMD_ENABLE:
               begin
                  if (cur.clk_s2)
                  begin
                     nxt.ctl_shadow[CTL_CONTROLLER_ENABLE] = 1'b1;
                     nxt.dev_wr = 1'b1;
                     nxt.dev_addr = DEV_USB_CONTROL;
                     nxt.dev_wdata = nxt.ctl_shadow;
                  end
                  else
                  begin
                     nxt.error = 1'b1;
                  end
               end
               CMD_SET_DEFAULT:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_ADDRESS;
                  nxt.dev_wdata = BYTE_ZERO;
                  nxt.dev_wdata[ADR_FUNCTION_ENABLE] = 1'b1;
                  nxt.ctl_shadow[CTL_ADDRESS_ENABLE] = 1'b0;
                  nxt.ctl_shadow[CTL_CONFIGURED] = 1'b0;
                  nxt.state = ST_ACCESS2;
               end
               CMD_SET_ADDRESS:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_ADDRESS;
                  nxt.dev_wdata = cur.arg[7:0] & ADDR_MASK;
                  nxt.dev_wdata[ADR_FUNCTION_ENABLE] = 1'b1;
                  nxt.ctl_shadow[CTL_ADDRESS_ENABLE] = 1'b1;
                  nxt.state = ST_ACCESS2;
               end
               CMD_SET_CONFIG:
               begin
                  nxt.ctl_shadow[CTL_CONFIGURED] = (cur.arg[7:0] != BYTE_ZERO);
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_USB_CONTROL;
                  nxt.dev_wdata = nxt.ctl_shadow;
               end
               CMD_CONFIG_EP:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_EP_CONTROL;
                  nxt.dev_wdata = ep_control(cur.arg[7] | (ep == 3'h0), cur.arg[2],
                                             cur.arg[1:0], ep);
               end
               CMD_FIFO_RESET:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_FIFO_RESET;
                  nxt.dev_wdata = 8'(1) << ep;
                  nxt.wr_count = 7'h00;
                  nxt.rd_count = 7'h00;
                  nxt.state = ST_ACCESS2;
               end
               CMD_READ_BYTE:
               begin
                  nxt.dev_rd = 1'b1;
                  nxt.dev_addr = DEV_EP_DATA;
                  nxt.rd_count = cur.rd_count + 7'h01;
                  nxt.state = ST_ACCESS2;
               end
               CMD_WRITE_BYTE:
               begin
                  if (cur.wr_count < fifo_size(ep))
                  begin
                     nxt.dev_wr = 1'b1;
                     nxt.dev_addr = DEV_EP_DATA;
                     nxt.dev_wdata = cur.arg[7:0];
                     nxt.wr_count = cur.wr_count + 7'h01;
                  end
                  else
                  begin
                     nxt.error = 1'b1;
                  end
               end
               CMD_READ_COUNT, CMD_READ_STATUS:
               begin
                  nxt.dev_rd = 1'b1;
                  nxt.dev_addr = (cur.cmd == CMD_READ_COUNT) ? DEV_BYTE_COUNT
                                                             : DEV_EP_STATUS;
                  nxt.rd_count = (cur.cmd == CMD_READ_COUNT) ? 7'h00 : cur.rd_count;
                  nxt.state = ST_ACCESS2;
               end
               CMD_RELEASE_OUT:
               begin
                  // Clear one bank flag; arg bit 0 picks bank 1 on the ping-pong endpoint.
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_EP_STATUS;
                  nxt.dev_wdata = 8'hff;
                  if (ep == PINGPONG_EP && cur.arg[0])
                  begin
                     nxt.dev_wdata[STA_OUT_BANK1] = 1'b0;
                  end
                  else
                  begin
                     nxt.dev_wdata[STA_OUT_BANK0] = 1'b0;
                  end
                  nxt.rd_count = 7'h00;
               end
               CMD_SEND_IN:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_EP_STATUS;
                  nxt.dev_wdata = BYTE_ZERO;
                  nxt.dev_wdata[STA_TX_READY] = 1'b1;
                  nxt.wr_count = 7'h00;
               end
               CMD_CANCEL_IN:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_EP_STATUS;
                  nxt.dev_wdata = 8'hff;
                  nxt.dev_wdata[STA_TX_READY] = 1'b0;
                  nxt.wr_count = 7'h00;
               end
               CMD_ACK_IN:
               begin
                  nxt.dev_wr = 1'b1;
                  nxt.dev_addr = DEV_EP_STATUS;
                  nxt.dev_wdata = 8'hff;
                  nxt.dev_wdata[STA_TX_COMPLETE] = 1'b0;
                  nxt.wr_count = 7'h00;
               end
               default:
               begin
                  nxt.error = 1'b1;
               end
            endcase
         end
         ST_ACCESS2:
         begin
            nxt.state = ST_DONE;
            if (cur.cmd == CMD_FIFO_RESET)
            begin
               nxt.dev_wr = 1'b1;
               nxt.dev_addr = DEV_FIFO_RESET;
               nxt.dev_wdata = BYTE_ZERO;
            end
            else if (cur.cmd == CMD_SET_DEFAULT || cur.cmd == CMD_SET_ADDRESS)
            begin
               nxt.dev_wr = 1'b1;
               nxt.dev_addr = DEV_USB_CONTROL;
               nxt.dev_wdata = cur.ctl_shadow;
            end
            else
            begin
               nxt.result = dev_rdata;
            end
         end
         ST_DONE:
         begin
            nxt.busy = 1'b0;
            nxt.state = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cur <= '0;
         cur.hreadyout <= 1'b1;
      end
      else
      begin
         cur <= nxt;
      end
   end

   assign hrdata = cur.hrdata;
   assign hreadyout = cur.hreadyout;
   assign hresp = 1'b0;
   assign dev_addr = cur.dev_addr;
   assign dev_wr = cur.dev_wr;
   assign dev_rd = cur.dev_rd;
   assign dev_wdata = cur.dev_wdata;
endmodule

// File: rtl/uefu_pkg.sv
// Constants and types for the USB endpoint firmware-side sequencer.
// Assumes a device register port with 8-bit data and a small address space.
// How it works
// - Enable controller only after reference clock runs.
// - After reset, set function enable for address 0.
// - New address written with function and address enable.
// - Configured bit follows non-zero SET_CONFIGURATION.
// - Disabled endpoints stay silent; endpoint 0 stays control.
// - FIFO reset: write bit one, then zero.
// - Data writes store byte, never exceed capacity.
// - Clear bank 0 flag after reading all bytes.
// - Ping-pong: clear a bank flag after emptying it.
// - Fill IN FIFO then set transmit ready.
// - Clearing transmit ready cancels the packet.
// - Clear transmit complete before refilling FIFO.
package uefu_pkg;
   // Device register indices on the device register port.
   localparam logic [3:0] DEV_USB_CONTROL = 4'h0;
   localparam logic [3:0] DEV_ADDRESS = 4'h1;
   localparam logic [3:0] DEV_EP_INDEX = 4'h2;
   localparam logic [3:0] DEV_EP_STATUS = 4'h3;
   localparam logic [3:0] DEV_EP_CONTROL = 4'h4;
   localparam logic [3:0] DEV_EP_DATA = 4'h5;
   localparam logic [3:0] DEV_BYTE_COUNT = 4'h6;
   localparam logic [3:0] DEV_FIFO_RESET = 4'h7;
   // Bit positions in device registers.
   localparam int CTL_CONTROLLER_ENABLE = 7;
   localparam int CTL_ADDRESS_ENABLE = 1;
   localparam int CTL_CONFIGURED = 0;
   localparam int ADR_FUNCTION_ENABLE = 7;
   localparam int CON_ENABLE = 7;
   localparam int CON_DIRECTION = 2;
   localparam int STA_OUT_BANK0 = 1;
   localparam int STA_OUT_BANK1 = 6;
   localparam int STA_TX_READY = 4;
   localparam int STA_TX_COMPLETE = 0;
   localparam logic [1:0] TYPE_CONTROL = 2'h0;
   localparam logic [1:0] TYPE_ISO = 2'h1;
   localparam logic [1:0] TYPE_BULK = 2'h2;
   localparam logic [1:0] TYPE_INTERRUPT = 2'h3;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] ADDR_MASK = 8'h7f;
   localparam logic [2:0] PINGPONG_EP = 3'h6;
   localparam int NUM_EP = 7;
   // Own AHB register word addresses (byte offsets).
   localparam logic [7:0] REG_COMMAND = 8'h00;
   localparam logic [7:0] REG_ARG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RESULT = 8'h0c;
   // Command codes written to REG_COMMAND bits 3:0.
   typedef enum logic [3:0] {
      CMD_NONE, CMD_ENABLE, CMD_SET_DEFAULT, CMD_SET_ADDRESS, CMD_SET_CONFIG,
      CMD_CONFIG_EP, CMD_FIFO_RESET, CMD_READ_BYTE, CMD_WRITE_BYTE,
      CMD_READ_COUNT, CMD_RELEASE_OUT, CMD_SEND_IN, CMD_CANCEL_IN,
      CMD_ACK_IN, CMD_READ_STATUS
   } uefu_cmd_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_INDEX, ST_ACCESS, ST_ACCESS2, ST_DONE
   } uefu_state_e;
endpackage

// File: testbench/tb.sv
// Testbench for the endpoint sequencer: AHB-Lite commands against a device model.
// Assumes the AHB register map and command codes of uefu_pkg.
module tb
   import uefu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic clock_ready = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata, res;
   logic hreadyout, hresp, dev_wr, dev_rd;
   logic [3:0] dev_addr;
   logic [7:0] dev_wdata, dev_rdata;
   logic [7:0] codes [NUM_EP] = '{8'h86, 8'h87, 8'h83, 8'h85, 8'h82, 8'h86, 8'h81};
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   always #12.5 hclk = ~hclk;
   uefu_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dev_addr(dev_addr), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_wdata(dev_wdata),
      .dev_rdata(dev_rdata), .clock_ready(clock_ready));
   uefu_dev_model u_dev (.hclk(hclk), .hresetn(hresetn), .dev_addr(dev_addr),
      .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata));
   // ==========================================
   // Tasks.
   task automatic results();
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      res = hrdata;
   endtask
   task automatic cmd(input uefu_cmd_e c, input logic [2:0] ep, input logic [7:0] d);
      ahb(1'b1, REG_ARG, {21'h00_0000, ep, d});
      ahb(1'b1, REG_COMMAND, {28'h000_0000, c});
      do ahb(1'b0, REG_STATUS, 32'h0000_0000); while (res[7] !== 1'b0);
      ahb(1'b0, REG_RESULT, 32'h0000_0000);
   endtask
   // ==========================================
   // Watchdog.
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_count++;
         results();
      end
   end
   // ==========================================
   // Main sequence.
   initial
   begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      clock_ready <= 1'b1;
      repeat (4) @(posedge hclk);
      cmd(CMD_ENABLE, 3'h0, 8'h00);
      check(u_dev.ctl[CTL_CONTROLLER_ENABLE], 1'b1);
      cmd(CMD_SET_DEFAULT, 3'h0, 8'h00);
      check(u_dev.adr, 8'h80);
      check(u_dev.ctl[CTL_ADDRESS_ENABLE], 1'b0);
      cmd(CMD_SET_ADDRESS, 3'h0, 8'h2a);
      check(u_dev.adr, 8'haa);
      check(u_dev.ctl[CTL_ADDRESS_ENABLE], 1'b1);
      cmd(CMD_SET_CONFIG, 3'h0, 8'h01);
      check(u_dev.ctl, 8'h83);
      cmd(CMD_SET_CONFIG, 3'h0, 8'h00);
      check(u_dev.ctl, 8'h82);
      for (int e = 0; e < NUM_EP; e++)
      begin
         cmd(CMD_CONFIG_EP, e[2:0], codes[e]);
         check(u_dev.con[e], (e == 0) ? 8'h80 : codes[e]);
      end
      cmd(CMD_ACK_IN, 3'h5, 8'h00);
      check(u_dev.sta[5][STA_TX_COMPLETE], 1'b0);
      cmd(CMD_FIFO_RESET, 3'h5, 8'h00);
      for (int i = 0; i < 3; i++)
         cmd(CMD_WRITE_BYTE, 3'h5, 8'ha0 + i[7:0]);
      check(u_dev.mem[5][2], 8'ha2);
      check(u_dev.ptr[5], 6'h03);
      check(u_dev.cnt[5], 8'h00);
      cmd(CMD_SEND_IN, 3'h5, 8'h00);
      check(u_dev.sta[5][STA_TX_READY], 1'b1);
      check(u_dev.in_nak[5], 1'b0);
      cmd(CMD_CANCEL_IN, 3'h5, 8'h00);
      check(u_dev.sta[5][STA_TX_READY], 1'b0);
      check(u_dev.in_nak[5], 1'b1);
      cmd(CMD_FIFO_RESET, 3'h5, 8'h00);
      check(u_dev.ptr[5], 6'h00);
      cmd(CMD_READ_COUNT, 3'h4, 8'h00);
      check(res[7:0], 8'h05);
      for (int i = 0; i < 5; i++)
      begin
         cmd(CMD_READ_BYTE, 3'h4, 8'h00);
         check(res[7:0], 8'h10 + i[7:0]);
      end
      cmd(CMD_READ_COUNT, 3'h4, 8'h00);
      check(res[7:0], 8'h05);
      cmd(CMD_READ_COUNT, 3'h1, 8'h00);
      check(res[7:0], 8'h0c);
      cmd(CMD_RELEASE_OUT, 3'h4, 8'h00);
      check(u_dev.sta[4][STA_OUT_BANK0], 1'b0);
      cmd(CMD_READ_STATUS, 3'h6, 8'h00);
      check(res[7:0], 8'h42);
      check(u_dev.out_nak6, 1'b1);
      cmd(CMD_RELEASE_OUT, 3'h6, 8'h00);
      check(u_dev.sta[6][STA_OUT_BANK0], 1'b0);
      check(u_dev.sta[6][STA_OUT_BANK1], 1'b1);
      check(u_dev.out_nak6, 1'b0);
      ahb(1'b0, 8'h10, 32'h0000_0000);
      check(res, 32'h0000_0000);
      check({hreadyout, hresp}, 2'b10);
      cmd(CMD_FIFO_RESET, 3'h1, 8'h00);
      for (int i = 0; i < 9; i++)
         cmd(CMD_WRITE_BYTE, 3'h1, 8'h55);
      ahb(1'b0, REG_STATUS, 32'h0000_0000);
      check(res[6], 1'b1);
      results();
   end
endmodule
bind uefu_host uefu_host_sva u_sva (.hclk(hclk), .hresetn(hresetn), .dev_addr(dev_addr),
   .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_wdata(dev_wdata), .clock_ready(clock_ready));

// File: testbench/uefu_dev_model.sv
// Behavioural model of the USB endpoint unit behind the device register port.
// Assumes one access per clock; read data stands while the read strobe is high.
module uefu_dev_model
   import uefu_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] dev_addr,
   input wire logic dev_wr,
   input wire logic dev_rd,
   input wire logic [7:0] dev_wdata,
   output logic [7:0] dev_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] ctl, adr, idx, rst_prev;
   logic [7:0] con [NUM_EP];
   logic [7:0] sta [NUM_EP];
   logic [7:0] cnt [NUM_EP];
   logic [5:0] ptr [NUM_EP];
   logic [7:0] mem [NUM_EP][64];
   logic [7:0] rd_val;
   logic [NUM_EP-1:0] in_nak;
   logic out_nak6;
   // The link itself is not modelled: these show the handshake the host would get.
   always_comb
   begin
      for (int e = 0; e < NUM_EP; e++)
         in_nak[e] = !sta[e][STA_TX_READY];
   end
   assign out_nak6 = sta[PINGPONG_EP][STA_OUT_BANK0] && sta[PINGPONG_EP][STA_OUT_BANK1];
   always_comb
   begin
      case (dev_addr)
         DEV_EP_DATA: rd_val = mem[idx[2:0]][ptr[idx[2:0]]];
         DEV_BYTE_COUNT: rd_val = cnt[idx[2:0]];
         DEV_EP_STATUS: rd_val = sta[idx[2:0]];
         DEV_EP_CONTROL: rd_val = con[idx[2:0]];
         default: rd_val = 8'h00;
      endcase
   end
   // Outside a read strobe the port shows the inverse, so a mistimed sample is caught.
   assign dev_rdata = dev_rd ? rd_val : ~rd_val;
   // Endpoint 4 holds a packet, endpoint 1 an oversize one, endpoint 6 both banks full.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctl <= 8'h00;
         adr <= 8'h00;
         idx <= 8'h00;
         rst_prev <= 8'h00;
         for (int e = 0; e < NUM_EP; e++)
         begin
            con[e] <= 8'h00;
            sta[e] <= (e == 4) ? 8'h02 : (e == 6) ? 8'h42 : (e == 5) ? 8'h01 : 8'h00;
            cnt[e] <= (e == 4) ? 8'h05 : (e == 1) ? 8'h0c : 8'h00;
            ptr[e] <= 6'h00;
            for (int i = 0; i < 64; i++)
               mem[e][i] <= 8'h10 + i[7:0];
         end
      end
      else
      begin
         if (dev_wr)
            case (dev_addr)
               DEV_USB_CONTROL: ctl <= dev_wdata;
               DEV_ADDRESS: adr <= dev_wdata;
               DEV_EP_INDEX: idx <= dev_wdata;
               DEV_EP_STATUS: sta[idx[2:0]] <= dev_wdata;
               DEV_EP_CONTROL: con[idx[2:0]] <= dev_wdata;
               DEV_EP_DATA:
               begin
                  mem[idx[2:0]][ptr[idx[2:0]]] <= dev_wdata;
                  ptr[idx[2:0]] <= ptr[idx[2:0]] + 6'h01;
               end
               DEV_FIFO_RESET:
               begin
                  rst_prev <= dev_wdata;
                  for (int e = 0; e < NUM_EP; e++)
                     if (rst_prev[e] && !dev_wdata[e])
                     begin
                        ptr[e] <= 6'h00;
                        cnt[e] <= 8'h00;
                     end
               end
               default: ;
            endcase
         if (dev_rd && dev_addr == DEV_EP_DATA)
            ptr[idx[2:0]] <= ptr[idx[2:0]] + 6'h01;
      end
   end
endmodule

// File: testbench/uefu_host_sva.sv
// Checker for the device register port of the endpoint sequencer.
// Assumes it is bound to uefu_host and sees only that module's ports.
module uefu_host_sva
   import uefu_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] dev_addr,
   input wire logic dev_wr,
   input wire logic dev_rd,
   input wire logic [7:0] dev_wdata,
   input wire logic clock_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // Helper: endpoint index last written to the device.
   logic [7:0] last_idx;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         last_idx <= BYTE_ZERO;
      else if (dev_wr && dev_addr == DEV_EP_INDEX)
         last_idx <= dev_wdata;
   end
   // ==========================================
   // Assertions.
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_enable_after_clock: assert property (dev_wr && dev_addr == DEV_USB_CONTROL
      && dev_wdata[CTL_CONTROLLER_ENABLE] |-> $past(clock_ready, 3))
      else $error("controller enabled without reference clock");
   a_default_addr_on: assert property (dev_wr && dev_addr == DEV_ADDRESS
      && dev_wdata[6:0] == 7'h00 |-> dev_wdata[ADR_FUNCTION_ENABLE])
      else $error("address 0 written without function enable");
   a_new_addr_on: assert property (dev_wr && dev_addr == DEV_ADDRESS
      && dev_wdata[6:0] != 7'h00 |-> dev_wdata[ADR_FUNCTION_ENABLE])
      else $error("new address written without function enable");
   a_index_in_range: assert property (dev_wr && dev_addr == DEV_EP_INDEX
      |-> dev_wdata < 8'h07)
      else $error("endpoint index out of range");
   a_ep0_control: assert property (dev_wr && dev_addr == DEV_EP_CONTROL
      && last_idx == 8'h00 |-> dev_wdata == 8'h80)
      else $error("endpoint 0 not enabled as control");
   a_fifo_reset_pair: assert property (dev_wr && dev_addr == DEV_FIFO_RESET
      && dev_wdata != 8'h00 |-> ##[1:4] (dev_wr && dev_addr == DEV_FIFO_RESET
      && dev_wdata == 8'h00))
      else $error("fifo reset bit not returned to zero");
   a_fifo_reset_one: assert property (dev_wr && dev_addr == DEV_FIFO_RESET
      && dev_wdata != 8'h00 |-> $onehot(dev_wdata))
      else $error("fifo reset touches several endpoints");
   a_data_read_once: assert property (dev_rd && dev_addr == DEV_EP_DATA
      |=> !dev_rd)
      else $error("more than one fifo byte read per command");
endmodule
